// ===== rtl/dmh_pkg.sv
// Purpose: Shared constants and types for the dual-mode host serial port
// Assumes: One system clock; all pins sampled through two flip-flops
// Notes: Register data and address are one byte wide
package dmh_pkg;
    localparam int DMH_DW = 8;
    localparam int DMH_AW = 8;
    localparam int DMH_HI_W = 5;
    localparam int DMH_CNT_W = 4;
    localparam logic [DMH_CNT_W-1:0] DMH_BYTE_BITS = 4'h8;
    localparam logic [DMH_CNT_W-1:0] DMH_SPI_LAST = 4'hF;
    localparam logic [DMH_CNT_W-1:0] DMH_SPI_WRAP = 4'h8;
    localparam logic [DMH_HI_W-1:0] DMH_ADDR_HI_RST = 5'h1A;
    localparam logic [DMH_DW-1:0] DMH_BYTE_RST = 8'h00;
    localparam real DMH_CLK_NS = 25.0;
    localparam real DMH_MIN_SCLK_NS = 200.0;
    localparam int DMH_SCLK_CYC = int'(DMH_MIN_SCLK_NS / DMH_CLK_NS);

    // Synchronised pin levels; sel high means I2C
    typedef struct packed {
        logic sel;
        logic scl;
        logic sda;
        logic a1;
        logic cs_n;
    } dmh_pins_t;

    localparam dmh_pins_t DMH_PINS_RST = '{sel: 1'b1, scl: 1'b1, sda: 1'b1,
        a1: 1'b1, cs_n: 1'b1};

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ACK_ADDR,
        I2C_WRITE,
        I2C_ACK_WRITE,
        I2C_READ,
        I2C_ACK_READ
    } dmh_i2c_st_t;
endpackage

// ===== rtl/dmh_serial_port.sv
// Purpose: Host configuration port, I2C slave or 3/4-wire SPI slave
// Assumes: CLK at least eight times the serial clock; REG_RDATA is
//          combinational from REG_ADDR
// Notes: SPI frame is one command byte (bit 7 read, bits 6:0 address)
//        then data bytes with auto-increment; I2C first written byte
//        is the register pointer
`timescale 1ns/1ps
`default_nettype none

module dmh_serial_port
    import dmh_pkg::*;
#(
    parameter logic [DMH_HI_W-1:0] ADDR_HI = DMH_ADDR_HI_RST
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic MODE_SEL,
    input wire logic SPI_3WIRE,
    input wire logic SCLK_IN,
    input wire logic DATA_IN,
    output logic DATA_OUT,
    output logic DATA_OE_N,
    input wire logic ADDR1_IN,
    output logic SDO_OUT,
    output logic SDO_OE_N,
    input wire logic CS_N_IN,
    input wire logic STATUS_EVENT,
    input wire logic STATUS_CLEAR,
    output logic STATUS_CHANGE_IRQ_N,
    output logic [DMH_AW-1:0] REG_ADDR,
    output logic [DMH_DW-1:0] REG_WDATA,
    output logic REG_WE,
    input wire logic [DMH_DW-1:0] REG_RDATA
);
    dmh_pins_t sy1, p;
    logic scl_q, sda_q, i2c_mode;
    logic scl_rise, scl_fall, start, stop;
    dmh_i2c_st_t i_state;
    logic [DMH_CNT_W-1:0] i_cnt;
    logic [DMH_DW-1:0] i_sh, i_out, i_ptr;
    logic i_pull, i_rw, i_first, i_wr;
    logic [DMH_CNT_W-1:0] s_cnt;
    logic [DMH_DW-1:0] s_sh, s_out;
    logic [DMH_AW-1:0] s_addr;
    logic s_rd, s_wr, s_inc, s_dr_oe;
    logic [DMH_HI_W+1:0] dev_addr;

    function automatic logic [DMH_CNT_W-1:0] spi_next(
        input logic [DMH_CNT_W-1:0] c);
        spi_next = (c == DMH_SPI_LAST) ? DMH_SPI_WRAP : c + 4'h1;
    endfunction

    // Pins cross from the host's world; serial clock is only sampled
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sy1 <= DMH_PINS_RST;
            p <= DMH_PINS_RST;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            sy1 <= '{sel: MODE_SEL, scl: SCLK_IN, sda: DATA_IN,
                a1: ADDR1_IN, cs_n: CS_N_IN};
            p <= sy1;
            scl_q <= p.scl;
            sda_q <= p.sda;
        end
    end

    assign scl_rise = p.scl & ~scl_q;
    assign scl_fall = ~p.scl & scl_q;
    assign start = p.scl & scl_q & sda_q & ~p.sda;
    assign stop = p.scl & scl_q & ~sda_q & p.sda;
    assign dev_addr = {ADDR_HI, p.a1, p.cs_n};

    // Strap follows only between transfers, so a glitch never splits a frame
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            i2c_mode <= 1'b1;
        end else if (i_state == I2C_IDLE && p.cs_n) begin
            i2c_mode <= p.sel;
        end
    end

    // I2C slave engine
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            i_state <= I2C_IDLE;
            i_cnt <= '0;
            i_sh <= DMH_BYTE_RST;
            i_out <= DMH_BYTE_RST;
            i_ptr <= DMH_BYTE_RST;
            i_pull <= 1'b0;
            i_rw <= 1'b0;
            i_first <= 1'b0;
            i_wr <= 1'b0;
        end else begin
            i_wr <= 1'b0;
            if (i_wr) begin
                i_ptr <= i_ptr + 8'h01;
            end
            if (!i2c_mode || stop) begin
                i_state <= I2C_IDLE;
                i_pull <= 1'b0;
            end else if (start) begin
                i_state <= I2C_ADDR;
                i_cnt <= '0;
                i_pull <= 1'b0;
            end else begin
                if (scl_rise) begin
                    i_sh <= {i_sh[6:0], p.sda};
                    i_cnt <= i_cnt + 4'h1;
                end
                if (scl_fall) begin
                    unique case (i_state)
                        I2C_ADDR: begin
                            if (i_cnt == DMH_BYTE_BITS) begin
                                if (i_sh[7:1] == dev_addr) begin
                                    i_pull <= 1'b1;
                                    i_rw <= i_sh[0];
                                    i_state <= I2C_ACK_ADDR;
                                end else begin
                                    i_state <= I2C_IDLE;
                                end
                            end
                        end
                        I2C_ACK_ADDR: begin
                            i_cnt <= '0;
                            if (i_rw) begin
                                i_out <= REG_RDATA;
                                i_pull <= ~REG_RDATA[7];
                                i_state <= I2C_READ;
                            end else begin
                                i_pull <= 1'b0;
                                i_first <= 1'b1;
                                i_state <= I2C_WRITE;
                            end
                        end
                        I2C_WRITE: begin
                            if (i_cnt == DMH_BYTE_BITS) begin
                                i_pull <= 1'b1;
                                i_first <= 1'b0;
                                i_state <= I2C_ACK_WRITE;
                                if (i_first) begin
                                    i_ptr <= i_sh;
                                end else begin
                                    i_wr <= 1'b1;
                                end
                            end
                        end
                        I2C_ACK_WRITE: begin
                            i_pull <= 1'b0;
                            i_cnt <= '0;
                            i_state <= I2C_WRITE;
                        end
                        I2C_READ: begin
                            if (i_cnt == DMH_BYTE_BITS) begin
                                i_pull <= 1'b0;
                                i_ptr <= i_ptr + 8'h01;
                                i_state <= I2C_ACK_READ;
                            end else begin
                                i_out <= {i_out[6:0], 1'b0};
                                i_pull <= ~i_out[6];
                            end
                        end
                        I2C_ACK_READ: begin
                            if (i_sh[0]) begin
                                i_state <= I2C_IDLE;
                            end else begin
                                i_cnt <= '0;
                                i_out <= REG_RDATA;
                                i_pull <= ~REG_RDATA[7];
                                i_state <= I2C_READ;
                            end
                        end
                        default: begin
                            i_state <= I2C_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // SPI slave engine, mode 0; select high aborts any frame at once
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s_cnt <= '0;
            s_sh <= DMH_BYTE_RST;
            s_out <= DMH_BYTE_RST;
            s_addr <= DMH_BYTE_RST;
            s_rd <= 1'b0;
            s_wr <= 1'b0;
            s_inc <= 1'b0;
            s_dr_oe <= 1'b0;
        end else if (i2c_mode || p.cs_n) begin
            s_cnt <= '0;
            s_wr <= 1'b0;
            s_inc <= 1'b0;
            s_dr_oe <= 1'b0;
        end else begin
            s_wr <= 1'b0;
            s_inc <= 1'b0;
            if (s_inc) begin
                s_addr <= s_addr + 8'h01;
            end
            if (scl_rise) begin
                s_sh <= {s_sh[6:0], p.sda};
                s_cnt <= spi_next(s_cnt);
                if (s_cnt == DMH_BYTE_BITS - 4'h1) begin
                    s_rd <= s_sh[6];
                    s_addr <= {1'b0, s_sh[5:0], p.sda};
                end
                if (s_cnt == DMH_SPI_LAST) begin
                    s_wr <= ~s_rd;
                    s_inc <= 1'b1;
                end
            end
            if (scl_fall && s_rd && s_cnt >= DMH_BYTE_BITS) begin
                s_dr_oe <= 1'b1;
                if (s_cnt == DMH_BYTE_BITS) begin
                    s_out <= REG_RDATA;
                end else begin
                    s_out <= {s_out[6:0], 1'b0};
                end
            end
        end
    end

    // Pin drivers; enables are low while driving
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            DATA_OUT <= 1'b1;
            DATA_OE_N <= 1'b1;
            SDO_OUT <= 1'b1;
            SDO_OE_N <= 1'b1;
        end else begin
            DATA_OUT <= i2c_mode ? 1'b0 : s_out[7];
            DATA_OE_N <= i2c_mode ? ~i_pull : ~(SPI_3WIRE & s_dr_oe);
            SDO_OUT <= s_out[7];
            SDO_OE_N <= ~(~i2c_mode & ~SPI_3WIRE & s_dr_oe & ~p.cs_n);
        end
    end

    // Register port toward the device core
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            REG_ADDR <= DMH_BYTE_RST;
            REG_WDATA <= DMH_BYTE_RST;
            REG_WE <= 1'b0;
        end else begin
            REG_ADDR <= i2c_mode ? i_ptr : s_addr;
            REG_WDATA <= i2c_mode ? i_sh : s_sh;
            REG_WE <= i2c_mode ? i_wr : s_wr;
        end
    end

    // Sticky status flag; a new event wins over a clear
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            STATUS_CHANGE_IRQ_N <= 1'b1;
        end else if (STATUS_EVENT) begin
            STATUS_CHANGE_IRQ_N <= 1'b0;
        end else if (STATUS_CLEAR) begin
            STATUS_CHANGE_IRQ_N <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_spi_quiet_i2c;
        !i2c_mode |-> i_state == I2C_IDLE && !i_pull;
    endproperty
    a_spi_quiet_i2c: assert property (p_spi_quiet_i2c)
        else $error("I2C engine active in SPI mode");
    property p_sda_open_drain;
        i2c_mode && !DATA_OE_N |-> !DATA_OUT;
    endproperty
    a_sda_open_drain: assert property (p_sda_open_drain)
        else $error("SDA driven high");
    property p_sdio_drive;
        !i2c_mode && SPI_3WIRE && s_dr_oe && $stable(SPI_3WIRE) |=> !DATA_OE_N;
    endproperty
    a_sdio_drive: assert property (p_sdio_drive)
        else $error("3-wire read data not driven");
    property p_sdi_input;
        !i2c_mode && !SPI_3WIRE ##1 !i2c_mode && !SPI_3WIRE |-> DATA_OE_N;
    endproperty
    a_sdi_input: assert property (p_sdi_input)
        else $error("Data pin driven in 4-wire mode");
    property p_a1_input;
        i2c_mode ##1 i2c_mode |-> SDO_OE_N;
    endproperty
    a_a1_input: assert property (p_a1_input)
        else $error("Address pin driven in I2C mode");
    property p_sdo_drive;
        !i2c_mode && !SPI_3WIRE && s_dr_oe && !p.cs_n |=> !SDO_OE_N && SDO_OUT == $past(s_out[7]);
    endproperty
    a_sdo_drive: assert property (p_sdo_drive)
        else $error("4-wire read data not on SDO");
    property p_addr_match;
        i_state == I2C_ADDR && i2c_mode && scl_fall && !stop && !start
            && i_cnt == DMH_BYTE_BITS && i_sh[7:1] == dev_addr
            |=> i_state == I2C_ACK_ADDR ##1 i_pull;
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("Own address not acknowledged");
    property p_cs_abort;
        p.cs_n |=> s_cnt == '0 && !s_dr_oe && !s_wr;
    endproperty
    a_cs_abort: assert property (p_cs_abort)
        else $error("SPI active without select");
    property p_irq_set;
        STATUS_EVENT |=> !STATUS_CHANGE_IRQ_N;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("Status change not flagged");
    property p_sdo_idle;
        i2c_mode || SPI_3WIRE || p.cs_n |=> SDO_OE_N;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("SDO driven while not selected");
endmodule

`default_nettype wire

// ===== verif/dmh_host_model.sv
// Purpose: Host master model driving the shared serial pins
// Assumes: Pins change on the falling CLK edge, phases of 4 CLK
// Notes: Undriven SPI lines toggle so a stale level never passes
`timescale 1ns/1ps
`default_nettype none
module dmh_host_model (
    input wire logic CLK,
    input wire logic i2c,
    input wire logic DATA_OUT,
    input wire logic DATA_OE_N,
    input wire logic SDO_OUT,
    input wire logic SDO_OE_N,
    output logic sclk,
    output logic cs_n,
    output logic a1,
    output wire logic data_w,
    output wire logic sdo_w
);
    logic hd = 1'b1;
    logic hoe = 1'b1;
    logic tog = 1'b0;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        a1 = 1'b1;
    end
    always @(posedge CLK) tog <= ~tog;
    // Open drain in I2C: either side may pull low
    assign data_w = !DATA_OE_N ? (DATA_OUT & (hoe ? hd : 1'b1))
        : (hoe ? hd : (i2c | tog));
    assign sdo_w = !SDO_OE_N ? SDO_OUT : (i2c ? a1 : tog);
    task automatic w4();
        repeat (4) @(negedge CLK);
    endtask
    // Data moves one CLK after the clock fall, never with it
    task automatic clk_bit(input logic b, input logic on_sdo, output logic s);
        @(negedge CLK);
        hd = b;
        repeat (3) @(negedge CLK);
        sclk = 1'b1;
        w4();
        s = on_sdo ? sdo_w : data_w;
        sclk = 1'b0;
    endtask
    task automatic spi_byte(input logic [7:0] tx, input logic rel, input logic on_sdo,
            output logic [7:0] rx);
        hoe = !rel;
        for (int i = 7; i >= 0; i--) clk_bit(tx[i], on_sdo, rx[i]);
    endtask
    task automatic i2c_start();
        hd = 1'b1;
        sclk = 1'b1;
        w4();
        hd = 1'b0;
        w4();
        sclk = 1'b0;
    endtask
    task automatic i2c_stop();
        @(negedge CLK);
        hd = 1'b0;
        w4();
        sclk = 1'b1;
        w4();
        hd = 1'b1;
        w4();
    endtask
    task automatic i2c_byte(input logic [7:0] tx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(tx[i], 1'b0, s);
        clk_bit(1'b1, 1'b0, ack);
    endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench for the dual-mode serial port
// Assumes: Core read data is the address xor 8'h5A
// Notes: Inputs change on the falling CLK edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dmh_pkg::*;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic MODE_SEL = 1'b1;
    logic SPI_3WIRE = 1'b0;
    logic ev = 1'b0;
    logic clr = 1'b0;
    logic bad_oe = 1'b0;
    wire logic sclk, cs_n, a1, data_w, sdo_w, d_out, d_oe_n, s_out, s_oe_n, irq_n, we;
    logic [DMH_AW-1:0] ra;
    logic [DMH_DW-1:0] wd, we_a, we_d;
    int failures = 0;
    int n_compared = 0;
    int we_n = 0;
    int cyc = 0;
    dmh_serial_port uut (.CLK(CLK), .RESET(RESET), .MODE_SEL(MODE_SEL),
        .SPI_3WIRE(SPI_3WIRE), .SCLK_IN(sclk), .DATA_IN(data_w), .DATA_OUT(d_out),
        .DATA_OE_N(d_oe_n), .ADDR1_IN(sdo_w), .SDO_OUT(s_out), .SDO_OE_N(s_oe_n),
        .CS_N_IN(cs_n), .STATUS_EVENT(ev), .STATUS_CLEAR(clr),
        .STATUS_CHANGE_IRQ_N(irq_n), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WE(we),
        .REG_RDATA(ra ^ 8'h5A));
    dmh_host_model host (.CLK(CLK), .i2c(MODE_SEL), .DATA_OUT(d_out), .DATA_OE_N(d_oe_n),
        .SDO_OUT(s_out), .SDO_OE_N(s_oe_n), .sclk(sclk), .cs_n(cs_n), .a1(a1),
        .data_w(data_w), .sdo_w(sdo_w));
    initial forever #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            finish_test();
        end
    end
    // Output enables must stay off outside their mode
    always @(posedge CLK) begin
        if (we === 1'b1) begin
            we_n++;
            we_a = ra;
            we_d = wd;
        end
        if (!RESET && (MODE_SEL || SPI_3WIRE) && s_oe_n !== 1'b1) bad_oe = 1'b1;
        if (!RESET && !MODE_SEL && !SPI_3WIRE && d_oe_n !== 1'b1) bad_oe = 1'b1;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic spi_frame(input logic [7:0] cmd, input logic [7:0] d0, input logic rd,
            output logic [7:0] rx);
        logic [7:0] junk;
        @(negedge CLK);
        host.cs_n = 1'b0;
        host.w4();
        host.spi_byte(cmd, 1'b0, 1'b0, junk);
        host.spi_byte(d0, rd & SPI_3WIRE, rd & !SPI_3WIRE, rx);
        host.w4();
        host.cs_n = 1'b1;
        host.hoe = 1'b1;
        repeat (8) @(negedge CLK);
    endtask
    task automatic t_irq();
        check("irq_idle", irq_n, 8'h01);
        ev = 1'b1;
        @(negedge CLK);
        ev = 1'b0;
        repeat (2) @(negedge CLK);
        check("irq_set", irq_n, 8'h00);
        clr = 1'b1;
        @(negedge CLK);
        clr = 1'b0;
        repeat (2) @(negedge CLK);
        check("irq_clear", irq_n, 8'h01);
        ev = 1'b1;
        clr = 1'b1;
        @(negedge CLK);
        ev = 1'b0;
        clr = 1'b0;
        repeat (2) @(negedge CLK);
        check("irq_event_wins", irq_n, 8'h00);
    endtask
    task automatic t_spi();
        logic [7:0] rx;
        int n;
        n = we_n;
        spi_frame(8'h10, 8'hA5, 1'b0, rx);
        check("spi_we", 8'(we_n - n), 8'h01);
        check("spi_addr", we_a, 8'h10);
        check("spi_wdata", we_d, 8'hA5);
        // Clocking with select high must not write
        host.spi_byte(8'h10, 1'b0, 1'b0, rx);
        host.spi_byte(8'h66, 1'b0, 1'b0, rx);
        repeat (8) @(negedge CLK);
        check("spi_no_cs", 8'(we_n - n), 8'h01);
        for (int m = 0; m < 2; m++) begin
            SPI_3WIRE = m[0];
            repeat (4) @(negedge CLK);
            spi_frame(8'hA2, 8'hFF, 1'b1, rx);
            check("spi_rdata", rx, 8'h22 ^ 8'h5A);
        end
        SPI_3WIRE = 1'b0;
    endtask
    task automatic t_i2c(input logic [6:0] dev, input logic ok);
        logic ack;
        int n;
        n = we_n;
        host.i2c_start();
        host.i2c_byte({dev, 1'b0}, ack);
        check("i2c_ack", ack, !ok);
        host.i2c_byte(8'h05, ack);
        host.i2c_byte(8'h3C, ack);
        host.i2c_stop();
        check("i2c_we", 8'(we_n - n), ok);
        if (ok) begin
            check("i2c_addr", we_a, 8'h05);
            check("i2c_wdata", we_d, 8'h3C);
        end
    endtask
    // Both select pins flipped; pointer left at 8'h06 by the one good write
    task automatic t_i2c_rd();
        logic ack;
        logic [7:0] rx;
        int n;
        n = we_n;
        host.a1 = 1'b0;
        host.cs_n = 1'b1;
        repeat (10) @(negedge CLK);
        host.i2c_start();
        host.i2c_byte({DMH_ADDR_HI_RST, 2'b01, 1'b1}, ack);
        check("i2c_rd_ack", ack, 8'h00);
        host.spi_byte(8'hFF, 1'b0, 1'b0, rx);
        host.clk_bit(1'b1, 1'b0, ack);
        host.i2c_stop();
        check("i2c_rdata", rx, 8'h06 ^ 8'h5A);
        check("i2c_rd_we", 8'(we_n - n), 8'h00);
    endtask
    initial begin
        repeat (10) @(negedge CLK);
        check("reset_out", {d_oe_n, s_oe_n, irq_n, we}, 8'h0E);
        RESET = 1'b0;
        repeat (8) @(negedge CLK);
        t_irq();
        MODE_SEL = 1'b0;
        host.sclk = 1'b0;
        repeat (10) @(negedge CLK);
        t_spi();
        MODE_SEL = 1'b1;
        host.sclk = 1'b1;
        repeat (10) @(negedge CLK);
        host.cs_n = 1'b0;
        repeat (10) @(negedge CLK);
        t_i2c({DMH_ADDR_HI_RST, 2'b10}, 1'b1);
        t_i2c({DMH_ADDR_HI_RST, 2'b00}, 1'b0);
        t_i2c({DMH_ADDR_HI_RST, 2'b11}, 1'b0);
        t_i2c_rd();
        check("oe_modes", bad_oe, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
